// *** inc/cks_pkg.sv ***
// Purpose: shared constants and types for the clock synthesizer control
// Assumes: one 250 MHz reference clock, phase-accumulator output dividers
// Notes: increments give f = inc * 250 MHz / 2^16
//
// Functional notes
// - select 00 floats all outputs; 01 gives 60 MHz, 10 gives 66 MHz host
// - select 11 is test mode; outputs are fixed fractions of test clock
// - host enable synchronized; low stops host clocks, others keep running
// - host clocks stop low and restart with a full high phase
// - host clocks resume within fewer than 4 host periods of enable rise
// - bus enable synchronized; low stops bus clocks, others unaffected
// - bus clocks stop low and restart with a complete high phase
// - bus clocks resume and stop within fewer than 4 clock periods
// - enable latency is one free-running bus clock edge per transition
// - sleep request is synchronized before power-down begins
// - power-down drives all outputs low before VCOs and oscillator stop
// - both enables are ignored while power-down is asserted
// - first valid clocks appear under 3 ms after sleep release
// - power-down latency short, at most two bus clock edges
// - no partial pulses entering or leaving power-down
// - internal clocks stay stopped until sleep request is released
package cks_pkg;

    localparam int CKS_PHASE_W = 16;
    localparam int CKS_CLK_MHZ = 250;

    // output frequency increments
    localparam logic [15:0] CKS_INC_HOST60 = 16'h3d71;
    localparam logic [15:0] CKS_INC_HOST66 = 16'h4444;
    localparam logic [15:0] CKS_INC_REF = 16'h0ea9;
    localparam logic [15:0] CKS_INC_24 = 16'h1893;
    localparam logic [15:0] CKS_INC_48 = 16'h3127;

    // frequency select encodings {high, low}
    localparam logic [1:0] CKS_SEL_FLOAT = 2'h0;
    localparam logic [1:0] CKS_SEL_60 = 2'h1;
    localparam logic [1:0] CKS_SEL_66 = 2'h2;
    localparam logic [1:0] CKS_SEL_TEST = 2'h3;

    // power-up timing
    localparam int CKS_OSC_WAIT_US = 1000;
    localparam int CKS_POWERUP_MS = 3;
    localparam int CKS_OSC_WAIT_CYC = CKS_OSC_WAIT_US * CKS_CLK_MHZ;
    localparam int CKS_POWERUP_CYC = CKS_POWERUP_MS * 1000 * CKS_CLK_MHZ;
    localparam int CKS_CNT_W = 20;

    // synchronizer reset value {sleep_n, bus_en, host_en}
    localparam logic [2:0] CKS_SYNC_RST = 3'h7;

    typedef enum logic [5:0] {
        CKS_ST_RUN = 6'h01,
        CKS_ST_GATE = 6'h02,
        CKS_ST_VCO_OFF = 6'h04,
        CKS_ST_SLEEP = 6'h08,
        CKS_ST_OSC_ON = 6'h10,
        CKS_ST_VCO_ON = 6'h20
    } cks_seq_t;

    typedef struct packed {
        logic [3:0] host;
        logic [7:0] bus;
        logic [2:0] refclk;
        logic intc;
        logic c24;
        logic [1:0] c48;
    } cks_clocks_t;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [15:0] acc_host;
        logic [15:0] acc_ref;
        logic [15:0] acc_24;
        logic [15:0] acc_48;
        logic raw_host;
        logic raw_bus;
        logic raw_ref;
        logic raw_24;
        logic raw_48;
        logic gate_host;
        logic gate_bus;
        logic gate_other;
        cks_seq_t seq;
        logic [19:0] cnt;
        logic osc_en;
        logic vco_en;
        logic oe_n;
        cks_clocks_t clk;
    } cks_state_t;

endpackage

// *** rtl/cks_clock_control.sv ***
// Purpose: digital control of the system clock synthesizer
// Assumes: ref_clk 250 MHz; test clock sampled as a synchronous input
// Notes: the analog PLL and crystal sit outside; vco_enable and
//        osc_enable steer them, pll_locked reports lock
`timescale 1ns/1ns
module cks_clock_control
    import cks_pkg::*;
#(
    parameter int OSC_WAIT_CYC = CKS_OSC_WAIT_CYC,
    parameter int POWERUP_CYC = CKS_POWERUP_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // frequency select and test clock
    input wire logic freq_select_low,
    input wire logic freq_select_high,
    input wire logic test_input_clock,
    // power-management controls, asynchronous
    input wire logic host_clock_gate_enable,
    input wire logic bus_clock_gate_enable,
    input wire logic sleep_request_n,
    // analog control
    input wire logic pll_locked,
    output logic vco_enable,
    output logic osc_enable,
    // clock outputs
    output logic [3:0] host_clock_outputs,
    output logic [7:0] bus_clock_outputs,
    output logic [2:0] reference_clock_out,
    output logic interrupt_controller_clock_out,
    output logic clock_24_out,
    output logic [1:0] clock_48_out,
    output logic clock_oe_n,
    // status
    output logic sleep_active
);

    // ------------------------------------------------------------------
    // gate update
    // ------------------------------------------------------------------
    // a gate may change only while the raw clock is low, so an output
    // never loses a high phase and never starts mid-pulse
    function automatic logic gate_upd(input logic gate, input logic raw,
                                      input logic want);
        gate_upd = raw ? gate : want;
    endfunction

    cks_state_t st_reg;
    cks_state_t st_next;
    logic [1:0] sel;
    logic active;
    logic run;
    logic host_want;
    logic bus_want;
    logic [15:0] host_inc;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        sel = {freq_select_high, freq_select_low};
        active = (sel != CKS_SEL_FLOAT);
        run = (st_reg.seq == CKS_ST_RUN);
        host_inc = (sel == CKS_SEL_66) ? CKS_INC_HOST66 : CKS_INC_HOST60;

        // two-flop synchronizers for the asynchronous controls
        st_next.sync1 = {sleep_request_n, bus_clock_gate_enable,
                         host_clock_gate_enable};
        st_next.sync2 = st_reg.sync1;

        // enables count only while running, power-down overrides them
        host_want = run && active && st_reg.sync2[0];
        bus_want = run && active && st_reg.sync2[1];

        // output dividers
        if (!st_reg.osc_en) begin
            // oscillator off: no internal clock runs at all
            st_next.acc_host = '0;
            st_next.acc_ref = '0;
            st_next.acc_24 = '0;
            st_next.acc_48 = '0;
            st_next.raw_host = 1'b0;
            st_next.raw_ref = 1'b0;
            st_next.raw_24 = 1'b0;
            st_next.raw_48 = 1'b0;
        end else if (sel == CKS_SEL_TEST) begin
            // test clock overdrives the crystal; reference runs at its rate
            st_next.raw_ref = test_input_clock;
            if (test_input_clock && !st_reg.raw_ref) begin
                st_next.raw_host = ~st_reg.raw_host;
            end
        end else begin
            st_next.acc_ref = st_reg.acc_ref + CKS_INC_REF;
            st_next.raw_ref = st_next.acc_ref[CKS_PHASE_W-1];
            if (st_reg.vco_en) begin
                st_next.acc_host = st_reg.acc_host + host_inc;
                st_next.acc_24 = st_reg.acc_24 + CKS_INC_24;
                st_next.acc_48 = st_reg.acc_48 + CKS_INC_48;
                st_next.raw_host = st_next.acc_host[CKS_PHASE_W-1];
                st_next.raw_24 = st_next.acc_24[CKS_PHASE_W-1];
                st_next.raw_48 = st_next.acc_48[CKS_PHASE_W-1];
            end else begin
                st_next.raw_host = 1'b0;
                st_next.raw_24 = 1'b0;
                st_next.raw_48 = 1'b0;
            end
        end

        // bus clock is host/2, toggled on each host rise
        if (!st_reg.osc_en) begin
            st_next.raw_bus = 1'b0;
        end else if (st_next.raw_host && !st_reg.raw_host) begin
            st_next.raw_bus = ~st_reg.raw_bus;
        end
        if (st_reg.osc_en && sel == CKS_SEL_TEST) begin
            st_next.raw_48 = st_next.raw_host;
            st_next.raw_24 = st_next.raw_bus;
        end

        // glitch-free gates
        st_next.gate_host = gate_upd(st_reg.gate_host, st_next.raw_host,
                                     host_want);
        st_next.gate_bus = gate_upd(st_reg.gate_bus, st_next.raw_bus,
                                    bus_want);
        st_next.gate_other = gate_upd(st_reg.gate_other,
                                      st_next.raw_ref | st_next.raw_24 |
                                      st_next.raw_48,
                                      run && active);

        // registered outputs
        st_next.oe_n = (sel == CKS_SEL_FLOAT);
        st_next.clk.host = {4{st_next.raw_host & st_next.gate_host}};
        st_next.clk.bus = {8{st_next.raw_bus & st_next.gate_bus}};
        st_next.clk.refclk = {3{st_next.raw_ref & st_next.gate_other}};
        st_next.clk.intc = st_next.raw_ref & st_next.gate_other;
        st_next.clk.c24 = st_next.raw_24 & st_next.gate_other;
        st_next.clk.c48 = {2{st_next.raw_48 & st_next.gate_other}};

        // power-down sequencer
        case (st_reg.seq)
            CKS_ST_RUN: begin
                if (!st_reg.sync2[2]) begin
                    st_next.seq = CKS_ST_GATE;
                end
            end
            CKS_ST_GATE: begin
                // wait until every output has settled low
                if (!st_reg.gate_host && !st_reg.gate_bus &&
                    !st_reg.gate_other) begin
                    st_next.seq = CKS_ST_VCO_OFF;
                    st_next.vco_en = 1'b0;
                end
            end
            CKS_ST_VCO_OFF: begin
                st_next.seq = CKS_ST_SLEEP;
                st_next.osc_en = 1'b0;
            end
            CKS_ST_SLEEP: begin
                if (st_reg.sync2[2]) begin
                    st_next.seq = CKS_ST_OSC_ON;
                    st_next.osc_en = 1'b1;
                    st_next.cnt = '0;
                end
            end
            CKS_ST_OSC_ON: begin
                st_next.cnt = st_reg.cnt + 20'h1;
                if (st_reg.cnt == CKS_CNT_W'(OSC_WAIT_CYC - 1)) begin
                    st_next.seq = CKS_ST_VCO_ON;
                    st_next.vco_en = 1'b1;
                end
            end
            CKS_ST_VCO_ON: begin
                // lock ends the wait; the limit keeps wake under 3 ms
                st_next.cnt = st_reg.cnt + 20'h1;
                if (pll_locked ||
                    st_reg.cnt == CKS_CNT_W'(POWERUP_CYC - 1)) begin
                    st_next.seq = CKS_ST_RUN;
                end
            end
            default: begin
                st_next.seq = CKS_ST_RUN;
                st_next.osc_en = 1'b1;
                st_next.vco_en = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.sync1 <= CKS_SYNC_RST;
            st_reg.sync2 <= CKS_SYNC_RST;
            st_reg.seq <= CKS_ST_RUN;
            st_reg.osc_en <= 1'b1;
            st_reg.vco_en <= 1'b1;
            st_reg.oe_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign vco_enable = st_reg.vco_en;
    assign osc_enable = st_reg.osc_en;
    assign host_clock_outputs = st_reg.clk.host;
    assign bus_clock_outputs = st_reg.clk.bus;
    assign reference_clock_out = st_reg.clk.refclk;
    assign interrupt_controller_clock_out = st_reg.clk.intc;
    assign clock_24_out = st_reg.clk.c24;
    assign clock_48_out = st_reg.clk.c48;
    assign clock_oe_n = st_reg.oe_n;
    assign sleep_active = st_reg.seq[3];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    host_full_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(st_reg.clk.host[0]) |-> $rose(st_reg.raw_host))
        else $error("host clock rose mid-pulse");

    bus_full_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(st_reg.clk.bus[0]) |-> $rose(st_reg.raw_bus))
        else $error("bus clock rose mid-pulse");

    host_stop_lat_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_reg.sync2[0] == 1'b0 && st_reg.osc_en && !st_reg.raw_host)
        |=> !st_reg.gate_host)
        else $error("host gate not closed in low phase");

    bus_stop_lat_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(st_reg.sync2[1]) |-> ##[1:20] !st_reg.clk.bus[0])
        else $error("bus clocks not stopped in time");

    float_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!freq_select_low && !freq_select_high) |=> st_reg.oe_n)
        else $error("outputs driven in float mode");

    sleep_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_reg.seq == CKS_ST_SLEEP) |-> (st_reg.clk == '0))
        else $error("clock output high while asleep");

    pd_ignore_en_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_reg.seq != CKS_ST_RUN) |=> !$rose(st_reg.gate_host) &&
        !$rose(st_reg.gate_bus))
        else $error("enable honoured during power-down");

    pd_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_reg.seq == CKS_ST_RUN && !st_reg.sync2[2])
        |=> st_reg.seq == CKS_ST_GATE)
        else $error("power-down not started");

    stop_order_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(st_reg.osc_en) |-> !st_reg.vco_en && $past(!st_reg.vco_en))
        else $error("oscillator stopped before VCOs");

    sleep_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_reg.seq == CKS_ST_SLEEP && !st_reg.sync2[2])
        |=> st_reg.seq == CKS_ST_SLEEP && !st_reg.osc_en)
        else $error("woke without release");

    wake_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_reg.seq == CKS_ST_VCO_ON)
        |-> st_reg.cnt < CKS_CNT_W'(POWERUP_CYC))
        else $error("power-up wait too long");

endmodule // cks_clock_control

// *** tb/cks_plat_model.sv ***
// Purpose: platform power manager and analog lock stand-in
// Assumes: bench requests change 1 ns after ref_clk rises
// Notes: keeps enables high for their minimum spans before dropping them
`timescale 1ns/1ns
module cks_plat_model #(
    // 100 host periods at 60 MHz and 10 bus periods, in ref_clk cycles
    parameter int HOST_HOLD = 420,
    parameter int BUS_HOLD = 84,
    parameter int LOCK_DLY = 8
) (
    // clock
    input wire logic ref_clk,
    // bench requests
    input wire logic want_host,
    input wire logic want_bus,
    input wire logic want_sleep_n,
    input wire logic test_on,
    input wire logic lock_never,
    // device side
    input wire logic vco_enable,
    output logic host_en,
    output logic bus_en,
    output logic sleep_n,
    output logic test_clk,
    output logic pll_locked
);
    int host_age = 0;
    int bus_age = 0;
    int lock_age = 0;
    int tdiv = 0;
    initial begin
        host_en = 1'b1;
        bus_en = 1'b1;
        sleep_n = 1'b1;
        test_clk = 1'b0;
        pll_locked = 1'b0;
    end
    // later than the bench, so its requests have already settled
    always @(posedge ref_clk) begin
        #2;
        host_age = host_en ? host_age + 1 : 0;
        bus_age = bus_en ? bus_age + 1 : 0;
        if (want_host || host_age >= HOST_HOLD) begin
            host_en = want_host;
        end
        if (want_bus || bus_age >= BUS_HOLD) begin
            bus_en = want_bus;
        end
        sleep_n = want_sleep_n;
        tdiv = tdiv + 1;
        test_clk = test_on & tdiv[2];
        lock_age = vco_enable ? lock_age + 1 : 0;
        pll_locked = !lock_never && lock_age > LOCK_DLY;
    end
endmodule // cks_plat_model

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the clock synthesizer control
// Assumes: select 01 (60 MHz host) while gating and power-down run
// Notes: oscillator and lock waits are shortened by parameters
`timescale 1ns/1ns
module testbench;
    import cks_pkg::*;
    localparam int OSC_W = 16;
    localparam int PWR_W = 64;
    // rises in 2500 cycles for host, bus, ref, 24, 48 per select value
    localparam int EXP [4][5] = '{'{0, 0, 0, 0, 0},
        '{600, 300, 143, 240, 480}, '{660, 330, 143, 240, 480},
        '{156, 78, 312, 78, 156}};
    localparam int MINW [5] = '{2, 4, 8, 5, 2};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic sel_lo = 1'b1;
    logic sel_hi = 1'b0;
    logic want_host = 1'b1;
    logic want_bus = 1'b1;
    logic want_sleep_n = 1'b1;
    logic test_on = 1'b0;
    logic lock_never = 1'b0;
    logic mon_on = 1'b0;
    logic host_en, bus_en, sleep_n, test_clk, pll_locked;
    logic vco_enable, osc_enable, oe_n, sleep_active;
    cks_clocks_t clk;
    logic [4:0] last = '0;
    logic [4:0] now_s;
    int run [5] = '{default: 0};
    int rises [5];
    int miscompares = 0;
    int checks = 0;

    always #2 ref_clk = ~ref_clk;

    cks_plat_model u_plat (
        .ref_clk(ref_clk), .want_host(want_host), .want_bus(want_bus),
        .want_sleep_n(want_sleep_n), .test_on(test_on),
        .lock_never(lock_never), .vco_enable(vco_enable),
        .host_en(host_en), .bus_en(bus_en), .sleep_n(sleep_n),
        .test_clk(test_clk), .pll_locked(pll_locked));

    cks_clock_control #(.OSC_WAIT_CYC(OSC_W), .POWERUP_CYC(PWR_W)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .freq_select_low(sel_lo),
        .freq_select_high(sel_hi), .test_input_clock(test_clk),
        .host_clock_gate_enable(host_en), .bus_clock_gate_enable(bus_en),
        .sleep_request_n(sleep_n), .pll_locked(pll_locked),
        .vco_enable(vco_enable), .osc_enable(osc_enable),
        .host_clock_outputs(clk.host), .bus_clock_outputs(clk.bus),
        .reference_clock_out(clk.refclk),
        .interrupt_controller_clock_out(clk.intc),
        .clock_24_out(clk.c24), .clock_48_out(clk.c48),
        .clock_oe_n(oe_n), .sleep_active(sleep_active));

    function automatic logic [4:0] taps();
        return {clk.c48[0], clk.c24, clk.refclk[0], clk.bus[0], clk.host[0]};
    endfunction

    task automatic check(input string what, input int lo, input int hi,
                         input logic [31:0] got);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            miscompares++;
            $display("ERROR %s expected %0d..%0d seen %0h", what, lo, hi, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic measure(input int n);
        logic [4:0] a;
        logic [4:0] b;
        rises = '{default: 0};
        b = taps();
        repeat (n) begin
            tick(1);
            a = taps();
            for (int i = 0; i < 5; i++) rises[i] += (a[i] && !b[i]);
            b = a;
        end
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // pulse widths are watched once mon_on is set; power-down ordering is watched all the time after reset
    always @(posedge ref_clk) begin
        #1;
        if (!rst) begin
            now_s = taps();
            for (int i = 0; i < 5; i++) begin
                if (mon_on && last[i] && !now_s[i]) begin
                    check("high width", MINW[i], 999, run[i]);
                end
                run[i] = now_s[i] ? run[i] + 1 : 0;
            end
            last = now_s;
            if (!vco_enable) check("held low", 0, 0, clk);
            if (!osc_enable) check("vco order", 0, 0, vco_enable);
        end
    end

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_modes();
        int e;
        for (int s = 0; s < 4; s++) begin
            {sel_hi, sel_lo} = s[1:0];
            test_on = (s == 3);
            tick(40);
            measure(2500);
            check("output float", s == 0, s == 0, oe_n);
            for (int g = 0; g < 5; g++) begin
                e = EXP[s][g];
                check("clock rises", (e > 2) ? e - e / 50 - 2 : 0, e + e / 50 + 2, rises[g]);
            end
        end
    endtask

    task automatic t_gate(input logic host);
        int n;
        if (host) want_host = 1'b0;
        else want_bus = 1'b0;
        repeat (600) if ((host ? host_en : bus_en) !== 1'b0) tick(1);
        tick(host ? 17 : 33);
        measure(300);
        check("gated stop", 0, 0, rises[host ? 0 : 1]);
        check("others run", 15, 99, rises[host ? 1 : 0] > 15 ? 15 : 0);
        check("ref runs", 10, 99, rises[2]);
        want_host = 1'b1;
        want_bus = 1'b1;
        n = 0;
        tick(1);
        while ((host ? clk.host[0] : clk.bus[0]) !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        check("resume", 0, 16, n);
    endtask

    task automatic t_sleep(input logic slow);
        int n;
        lock_never = slow;
        want_sleep_n = 1'b0;
        tick(22);
        check("sleep entered", 1, 1, sleep_active);
        check("osc off", 0, 0, osc_enable);
        want_host = 1'b0;
        want_bus = 1'b0;
        tick(90);
        want_host = 1'b1;
        want_bus = 1'b1;
        measure(100);
        check("asleep quiet", 0, 0, rises[0] + rises[1] + rises[2]);
        check("still asleep", 1, 1, sleep_active);
        want_sleep_n = 1'b1;
        n = 0;
        while (vco_enable !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        check("vco wait", OSC_W, OSC_W + 6, n);
        while (clk.host[0] !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        check("wake time", slow ? PWR_W / 2 : OSC_W, slow ? PWR_W + 20 : OSC_W + 30, n);
        lock_never = 1'b0;
    endtask

    // ---------------------------------------------------------------
    // run
    // ---------------------------------------------------------------
    initial begin
        tick(5);
        check("reset state", 1, 1, oe_n && vco_enable && osc_enable);
        check("reset clocks", 0, 0, {clk, sleep_active});
        tick(1);
        rst = 1'b0;
        t_modes();
        {sel_hi, sel_lo} = 2'h1;
        test_on = 1'b0;
        tick(20);
        mon_on = 1'b1;
        t_gate(1'b1);
        t_gate(1'b0);
        t_sleep(1'b0);
        t_sleep(1'b1);
        report_and_stop();
    end

    // the whole run needs some 11500 cycles; allow about four times that
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule // testbench
